// *** core/das_pkg.sv ***
// Purpose: shared constants and carriers for the acquisition register bank
// Assumes: byte-wide host bus, one clock
// Notes: offsets are the byte offsets of the host port
package das_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int CHAN_W = 4;
    localparam int RANGE_W = 4;
    localparam int CODE_W = 12;
    localparam int GP_W = 16;
    localparam int IRQ_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_SW_TRIGGER = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_RANGE = 5'h01;
    localparam logic [ADDR_W-1:0] OFS_SCAN = 5'h02;
    localparam logic [ADDR_W-1:0] OFS_GP_LOW = 5'h03;
    localparam logic [ADDR_W-1:0] OFS_AOUT_LOW = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_AOUT_HIGH = 5'h05;
    localparam logic [ADDR_W-1:0] OFS_FIFO_IRQ = 5'h06;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h09;
    localparam logic [ADDR_W-1:0] OFS_GP_HIGH = 5'h0b;

    // field positions
    localparam int SCAN_STOP_LSB = 4;
    localparam int AOUT_LOW_LSB = 4;
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_CONFIG_BIT = 5;
    localparam int ST_DONE_BIT = 4;
    localparam int CTL_IRQ_EN_BIT = 7;
    localparam int CTL_LINE_LSB = 4;
    localparam int CTL_LINE_W = 3;
    localparam int CTL_XFER_BIT = 2;
    localparam int CTL_TRIG_LSB = 0;
    localparam int FIFO_IRQ_BIT = 0;
    localparam int FIRST_IRQ_LINE = 2;

    // reset values and fixed answers
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] READ_NONE = 8'h00;
    localparam logic [CODE_W-1:0] RST_CODE = 12'h000;

    // trigger source codes
    localparam logic [1:0] TRIG_EXTERNAL = 2'h2;
    localparam logic [1:0] TRIG_PACER = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] data;
    } bus_req_t;

    typedef struct packed {
        logic irq_gen_enable;
        logic [CTL_LINE_W-1:0] irq_line_sel;
        logic spare;
        logic xfer_req_enable;
        logic [1:0] trig_src_sel;
    } control_t;

    typedef enum logic [2:0] {
        XFER_IDLE = 3'b001,
        XFER_FIRST = 3'b010,
        XFER_SECOND = 3'b100
    } xfer_state_t;

endpackage : das_pkg

// *** core/range_table.sv ***
// Purpose: per-channel range code store
// Assumes: one write port, one registered read port
// Notes: read data lag the read index by one cycle
module range_table #(
    parameter int DEPTH = 16,
    parameter int IDX_W = 4,
    parameter int DW = 4
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic [IDX_W-1:0] rd_idx_i,
    output logic [DW-1:0] rd_data_o
);
    logic [DW-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            mem_q[wr_idx_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= '0;
        end else if (ce_i) begin
            rd_data_o <= mem_q[rd_idx_i];
        end
    end
endmodule : range_table

// *** core/xfer_pair.sv ***
// Purpose: issues two successive transfer requests per finished conversion
// Assumes: the transfer controller answers each request with an acknowledge pulse
// Notes: a start while a pair is running is dropped
module xfer_pair (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic ack_i,
    output logic req_o,
    output logic busy_o
);
    import das_pkg::*;

    xfer_state_t state_q;
    xfer_state_t state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            XFER_IDLE: begin
                if (start_i) begin
                    state_d = XFER_FIRST;
                end
            end
            XFER_FIRST: begin
                if (ack_i) begin
                    state_d = XFER_SECOND;
                end
            end
            XFER_SECOND: begin
                if (ack_i) begin
                    state_d = XFER_IDLE;
                end
            end
            default: state_d = XFER_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= XFER_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    assign req_o = (state_q != XFER_IDLE);
    assign busy_o = (state_q != XFER_IDLE);
endmodule : xfer_pair

// *** core/das_regs.sv ***
// Purpose: host register bank of a data acquisition module
// Assumes: host strobes are single-cycle and synchronous to clk_i
// Notes: read data appear one cycle after the read strobe
// Function
// - scan register holds stop high, start low
// - scan write loads current channel with start
// - trigger advances channel, wraps stop to start
// - range write stored for start channel
// - two 8-bit ports, read inputs, write outputs
// - output code from low high nibble, high byte
// - high byte write updates whole code at once
// - fifo interrupt enable bit, write only
// - status write clears done flag and pending interrupt
// - status bit 7 shows conversion busy
// - config bit shows single-ended or differential
// - completion sets done, may raise interrupt
// - low status bits show next channel
// - control bit 7 gates interrupt generation
// - interrupt source conversion or terminal count
// - line field codes 2..7 select lines
// - with control bit 2 set, a conversion issues two transfer requests
// - control bits 1..0 pick trigger source
// - software trigger by write to offset 0
module das_regs (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire das_pkg::bus_req_t bus_i,
    output logic [das_pkg::DATA_W-1:0] rdata_o,
    input wire logic [das_pkg::GP_W-1:0] gp_port_bit_i,
    output logic [das_pkg::GP_W-1:0] gp_port_bit_o,
    output logic [das_pkg::CODE_W-1:0] analog_out_code_o,
    output logic fifo_irq_enable_o,
    input wire logic input_config_flag_i,
    input wire logic ext_trig_i,
    input wire logic pacer_tick_i,
    input wire logic conv_done_i,
    input wire logic term_count_i,
    input wire logic xfer_ack_i,
    output logic conv_start_o,
    output logic [das_pkg::CHAN_W-1:0] next_input_index_o,
    output logic [das_pkg::RANGE_W-1:0] gain_range_code_o,
    output logic [das_pkg::IRQ_W-1:0] irq_o,
    output logic xfer_req_o
);
    import das_pkg::*;

    logic [DATA_W-1:0] scan_q;
    logic [CHAN_W-1:0] chan_q;
    logic [CHAN_W-1:0] chan_d;
    logic [DATA_W-1:0] gp_low_q;
    logic [DATA_W-1:0] gp_high_q;
    logic [DATA_W-1:0] aout_low_q;
    logic [CODE_W-1:0] aout_code_q;
    logic fifo_en_q;
    control_t ctrl_q;
    logic busy_q;
    logic done_q;
    logic irq_pend_q;
    logic start_q;
    logic [IRQ_W-1:0] irq_q;
    logic [DATA_W-1:0] rdata_q;

    // write decode
    wire wr_sw = bus_i.wr && (bus_i.addr == OFS_SW_TRIGGER);
    wire wr_range = bus_i.wr && (bus_i.addr == OFS_RANGE);
    wire wr_scan = bus_i.wr && (bus_i.addr == OFS_SCAN);
    wire wr_gp_low = bus_i.wr && (bus_i.addr == OFS_GP_LOW);
    wire wr_aout_low = bus_i.wr && (bus_i.addr == OFS_AOUT_LOW);
    wire wr_aout_high = bus_i.wr && (bus_i.addr == OFS_AOUT_HIGH);
    wire wr_fifo = bus_i.wr && (bus_i.addr == OFS_FIFO_IRQ);
    wire wr_status = bus_i.wr && (bus_i.addr == OFS_STATUS);
    wire wr_ctrl = bus_i.wr && (bus_i.addr == OFS_CONTROL);
    wire wr_gp_high = bus_i.wr && (bus_i.addr == OFS_GP_HIGH);

    // stop in upper nibble, start in lower
    wire [CHAN_W-1:0] scan_first_index = scan_q[CHAN_W-1:0];
    wire [CHAN_W-1:0] scan_stop_index = scan_q[SCAN_STOP_LSB +: CHAN_W];

    wire trig_sw = wr_sw && !ctrl_q.trig_src_sel[1];
    wire trig_ext = (ctrl_q.trig_src_sel == TRIG_EXTERNAL) && ext_trig_i;
    wire trig_pacer = (ctrl_q.trig_src_sel == TRIG_PACER) && pacer_tick_i;
    wire trigger = trig_sw || trig_ext || trig_pacer;

    // scan write reloads the start channel
    // wrap from stop back to start
    wire at_stop = (chan_q == scan_stop_index);
    wire [CHAN_W-1:0] chan_step = at_stop ? scan_first_index : chan_q + 1'b1;
    assign chan_d = wr_scan ? bus_i.data[CHAN_W-1:0] : (trigger ? chan_step : chan_q);

    // interrupt source follows the transfer enable
    wire irq_event = ctrl_q.xfer_req_enable ? term_count_i : conv_done_i;

    // conversion done starts a request pair
    wire xfer_start = conv_done_i && ctrl_q.xfer_req_enable;

    wire busy_d = conv_done_i ? 1'b0 : (trigger ? 1'b1 : busy_q);

    wire [DATA_W-1:0] status_byte = {busy_q, 1'b0, input_config_flag_i, done_q, chan_q};

    // read select; write-only and unmapped offsets read as zero
    wire [DATA_W-1:0] read_sel =
        (bus_i.addr == OFS_SCAN) ? scan_q :
        (bus_i.addr == OFS_GP_LOW) ? gp_port_bit_i[DATA_W-1:0] :
        (bus_i.addr == OFS_GP_HIGH) ? gp_port_bit_i[GP_W-1:DATA_W] :
        (bus_i.addr == OFS_STATUS) ? status_byte :
        (bus_i.addr == OFS_CONTROL) ? ctrl_q :
        READ_NONE;

    // range code goes to the start-channel slot
    range_table #(
        .DEPTH(1 << CHAN_W),
        .IDX_W(CHAN_W),
        .DW(RANGE_W)
    ) u_range (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .wr_en_i(wr_range),
        .wr_idx_i(scan_first_index),
        .wr_data_i(bus_i.data[RANGE_W-1:0]),
        .rd_idx_i(chan_d),
        .rd_data_o(gain_range_code_o)
    );

    logic xfer_req;
    xfer_pair u_xfer (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .start_i(xfer_start),
        .ack_i(xfer_ack_i),
        .req_o(xfer_req),
        .busy_o()
    );

    // scan, channel and digital ports
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scan_q <= RST_BYTE;
            chan_q <= '0;
            gp_low_q <= RST_BYTE;
            gp_high_q <= RST_BYTE;
        end else if (ce_i) begin
            if (wr_scan) begin
                scan_q <= bus_i.data;
            end
            chan_q <= chan_d;
            if (wr_gp_low) begin
                gp_low_q <= bus_i.data;
            end
            if (wr_gp_high) begin
                gp_high_q <= bus_i.data;
            end
        end
    end

    // analog output double buffer
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aout_low_q <= RST_BYTE;
            aout_code_q <= RST_CODE;
        end else if (ce_i) begin
            if (wr_aout_low) begin
                aout_low_q <= bus_i.data;
            end
            // high write moves the whole code
            if (wr_aout_high) begin
                aout_code_q <= {bus_i.data, aout_low_q[AOUT_LOW_LSB +: CHAN_W]};
            end
        end
    end

    // control, fifo enable and conversion flags
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= '0;
            fifo_en_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            irq_pend_q <= 1'b0;
            start_q <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                ctrl_q <= bus_i.data;
            end
            if (wr_fifo) begin
                fifo_en_q <= bus_i.data[FIFO_IRQ_BIT];
            end
            busy_q <= busy_d;
            start_q <= trigger;
            done_q <= conv_done_i || (done_q && !wr_status);
            irq_pend_q <= irq_event || (irq_pend_q && !wr_status);
        end
    end

    for (genvar n = 0; n < IRQ_W; n++) begin : g_irq
        wire line_hit = (n >= FIRST_IRQ_LINE) && (ctrl_q.irq_line_sel == CTL_LINE_W'(n));
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                irq_q[n] <= 1'b0;
            end else if (ce_i) begin
                irq_q[n] <= ctrl_q.irq_gen_enable && irq_pend_q && line_hit;
            end
        end
    end

    // registered read data
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= READ_NONE;
        end else if (ce_i && bus_i.rd) begin
            rdata_q <= read_sel;
        end
    end

    assign rdata_o = rdata_q;
    assign gp_port_bit_o = {gp_high_q, gp_low_q};
    assign analog_out_code_o = aout_code_q;
    assign fifo_irq_enable_o = fifo_en_q;
    assign conv_start_o = start_q;
    assign next_input_index_o = chan_q;
    assign irq_o = irq_q;
    assign xfer_req_o = xfer_req;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_scan_load: assert property (ce_i && wr_scan |=> chan_q == $past(bus_i.data[3:0]))
        else $error("channel not loaded from scan write");
    a_chan_wrap: assert property (ce_i && trigger && !wr_scan && at_stop
        |=> chan_q == $past(scan_first_index))
        else $error("channel did not wrap to start");
    a_chan_step: assert property (ce_i && trigger && !wr_scan && !at_stop
        |=> chan_q == $past(chan_q) + 4'h1)
        else $error("channel did not advance");
    a_dac_hold: assert property (ce_i && wr_aout_low |=> $stable(analog_out_code_o))
        else $error("low byte changed converter code");
    a_dac_load: assert property (ce_i && wr_aout_high && !wr_aout_low
        |=> analog_out_code_o == {$past(bus_i.data), $past(aout_low_q[7:4])})
        else $error("converter code mismatch");
    a_done_clear: assert property (ce_i && wr_status && !conv_done_i |=> !done_q)
        else $error("status write did not clear done");
    a_done_set: assert property (ce_i && conv_done_i |=> done_q && !busy_q)
        else $error("done flag not set");
    a_irq_gate: assert property (irq_o != 8'h00 |-> $past(ctrl_q.irq_gen_enable))
        else $error("interrupt without enable");
    a_irq_none_low: assert property (irq_o[1:0] == 2'h0)
        else $error("interrupt on unused line");
    a_xfer_pair: assert property (ce_i && xfer_start && !xfer_req |=> xfer_req)
        else $error("transfer request not issued");
    a_status_busy: assert property (ce_i && bus_i.rd && bus_i.addr == OFS_STATUS
        |=> rdata_o[7] == $past(busy_q))
        else $error("busy bit misreported");
    a_sw_trigger: assert property (ce_i && trig_sw |=> conv_start_o)
        else $error("software trigger lost");

    c_scan_wrap: cover property (ce_i && trigger && at_stop);
    c_irq_raised: cover property (irq_o != 8'h00);
    c_xfer_two: cover property (xfer_req ##1 xfer_ack_i ##1 xfer_req);
endmodule : das_regs

// *** tb/dma_partner.sv ***
// Purpose: transfer controller on the far side of the request line
// Assumes: one acknowledge pulse per request, prompt or slow
// Notes: every second acknowledge comes with a terminal count pulse in the same cycle
module dma_partner (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic req_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic tc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_n;
    int half;
    // pair of acks, terminal count with the second
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_o <= 1'b0;
            tc_o <= 1'b0;
            wait_n <= 0;
            half <= 0;
        end else begin
            ack_o <= 1'b0;
            tc_o <= 1'b0;
            if (req_i === 1'b1 && !ack_o) begin
                if (wait_n >= (slow_i ? 4 : 1)) begin
                    ack_o <= 1'b1;
                    wait_n <= 0;
                    half <= (half + 1) % 2;
                    tc_o <= (half == 1);
                end else begin
                    wait_n <= wait_n + 1;
                end
            end
        end
    end
endmodule : dma_partner

// *** tb/das_regs_tb_top.sv ***
// Purpose: self-checking bench for the acquisition register bank
// Assumes: host strobes driven on the falling edge, two cycles per access
// Notes: a behavioural model tracks channel, busy, done and codes
module das_regs_tb_top import das_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    bus_req_t bus_i = '0;
    logic [DATA_W-1:0] rdata_o;
    logic [GP_W-1:0] gp_in = '0;
    logic [GP_W-1:0] gp_out;
    logic [CODE_W-1:0] aout;
    logic fifo_en;
    logic cfg = 1'b0;
    logic ext = 1'b0;
    logic pacer = 1'b0;
    logic cdone = 1'b0;
    logic slow = 1'b0;
    logic tc, ack, cstart, xreq;
    logic [CHAN_W-1:0] chan;
    logic [RANGE_W-1:0] gain;
    logic [IRQ_W-1:0] irq;
    int fails = 0;
    int checked = 0;
    int starts = 0;
    int acks = 0;
    int m_start, m_stop, m_chan, m_busy, m_done, m_starts, m_code, v, lo, hi, a0;
    int rng[16];

    always #2.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (cstart === 1'b1) begin
            starts++;
        end
        if (ack === 1'b1) begin
            acks++;
        end
    end

    das_regs i_das_regs (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .bus_i(bus_i),
        .rdata_o(rdata_o), .gp_port_bit_i(gp_in), .gp_port_bit_o(gp_out),
        .analog_out_code_o(aout), .fifo_irq_enable_o(fifo_en), .input_config_flag_i(cfg),
        .ext_trig_i(ext), .pacer_tick_i(pacer), .conv_done_i(cdone), .term_count_i(tc),
        .xfer_ack_i(ack), .conv_start_o(cstart), .next_input_index_o(chan),
        .gain_range_code_o(gain), .irq_o(irq), .xfer_req_o(xreq));

    dma_partner i_dma_partner (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(xreq),
        .slow_i(slow), .ack_o(ack), .tc_o(tc));

    task automatic report_and_stop();
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one access; rd when wr is low, data settled two edges later
    task automatic host(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d);
        bus_i.addr = a;
        bus_i.data = d;
        bus_i.wr = w;
        bus_i.rd = !w;
        @(negedge clk_i);
        bus_i.wr = 1'b0;
        bus_i.rd = 1'b0;
        @(negedge clk_i);
    endtask : host

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
        @(negedge clk_i);
    endtask : pulse

    function automatic void adv();
        m_chan = (m_chan == m_stop) ? m_start : (m_chan + 1) % 16;
        m_busy = 1;
        m_starts++;
    endfunction : adv

    task automatic scan(input int d);
        host(OFS_SCAN, 1'b1, 8'(d));
        m_start = d % 16;
        m_stop = d / 16;
        m_chan = m_start;
    endtask : scan

    task automatic status_chk();
        host(OFS_STATUS, 1'b0, 8'h00);
        check(rdata_o, 16'(m_busy * 128 + cfg * 32 + m_done * 16 + m_chan));
    endtask : status_chk

    task automatic done_pulse();
        pulse(cdone);
        m_busy = 0;
        m_done = 1;
        @(negedge clk_i);
    endtask : done_pulse

    task automatic clear_done();
        host(OFS_STATUS, 1'b1, 8'($urandom));
        m_done = 0;
    endtask : clear_done

    initial begin
        m_busy = 0;
        m_done = 0;
        m_starts = 0;
        m_code = 0;
        m_chan = 0;
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'b1;
        v = $urandom(434);
        @(negedge clk_i);
        host(OFS_CONTROL, 1'b1, 8'h00);
        for (int c = 0; c < 16; c++) begin
            scan(c);
            rng[c] = $urandom % 16;
            host(OFS_RANGE, 1'b1, 8'(rng[c]));
        end
        scan(8'h73);
        host(OFS_SCAN, 1'b0, 8'h00);
        check(rdata_o, 16'h0073);
        check(chan, 16'(m_chan));
        for (int i = 0; i < 7; i++) begin
            host(OFS_SW_TRIGGER, 1'b1, 8'($urandom));
            adv();
            check(chan, 16'(m_chan));
            check(gain, 16'(rng[m_chan]));
            status_chk();
        end
        for (int k = 0; k < 2; k++) begin
            cfg = 1'(k);
            done_pulse();
            status_chk();
            clear_done();
            status_chk();
        end
        for (int i = 0; i < 4; i++) begin
            gp_in = 16'($urandom);
            lo = $urandom % 256;
            hi = $urandom % 256;
            host(OFS_GP_LOW, 1'b1, 8'(lo));
            host(OFS_GP_HIGH, 1'b1, 8'(hi));
            check(gp_out, 16'(hi * 256 + lo));
            host(OFS_GP_LOW, 1'b0, 8'h00);
            check(rdata_o, 16'(gp_in[7:0]));
            host(OFS_GP_HIGH, 1'b0, 8'h00);
            check(rdata_o, 16'(gp_in[15:8]));
            host(OFS_AOUT_LOW, 1'b1, 8'(lo));
            check(aout, 16'(m_code));
            host(OFS_AOUT_HIGH, 1'b1, 8'(hi));
            m_code = hi * 16 + lo / 16;
            check(aout, 16'(m_code));
            host(OFS_FIFO_IRQ, 1'b1, 8'(hi * 2 + i % 2));
            check(fifo_en, 16'(i % 2));
        end
        for (int n = 0; n < 16; n++) begin
            v = (n % 2) * 128 + (n / 2) * 16;
            host(OFS_CONTROL, 1'b1, 8'(v));
            host(OFS_CONTROL, 1'b0, 8'h00);
            check(rdata_o, 16'(v));
            host(OFS_SW_TRIGGER, 1'b1, 8'h00);
            adv();
            done_pulse();
            @(negedge clk_i);
            check(irq, (n % 2 == 1 && n / 2 >= 2) ? 16'(1 << (n / 2)) : 16'h0);
            // host clears done after checking the interrupt lines
            clear_done();
            check(irq, 16'h0);
        end
        for (int s = 0; s < 4; s++) begin
            host(OFS_CONTROL, 1'b1, 8'(s));
            host(OFS_SW_TRIGGER, 1'b1, 8'h00);
            if (s < 2) adv();
            pulse(ext);
            if (s == 2) adv();
            pulse(pacer);
            if (s == 3) adv();
            check(chan, 16'(m_chan));
            check(starts, 16'(m_starts));
        end
        for (int k = 0; k < 2; k++) begin
            slow = 1'(k);
            a0 = acks;
            host(OFS_CONTROL, 1'b1, 8'hb4);
            done_pulse();
            check(irq, 16'h0);
            v = 0;
            while (xreq !== 1'b0 && v < 60) begin
                @(negedge clk_i);
                v++;
            end
            if (v == 60) begin
                fails++;
                report_and_stop();
            end
            repeat (3) @(negedge clk_i);
            check(acks - a0, 16'h2);
            check(irq, 16'h0008);
            clear_done();
            status_chk();
        end
        report_and_stop();
    end
endmodule : das_regs_tb_top
